/* verilog/ipc_defines.vh */
// constants for the interrupt priority slot register block
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH

// register byte offsets
`define IPC_ADDR_W          12
`define IPC_OFF_SLOTS       12'h000
`define IPC_OFF_STATUS      12'h004

// slot layout within each byte lane
`define IPC_SLOT_W          8
`define IPC_PRIO_MSB        4
`define IPC_PRIO_LSB        2
`define IPC_SUB_MSB         1
`define IPC_SUB_LSB         0
`define IPC_SLOT_MASK       8'h1f
`define IPC_NUM_SLOTS       4

// reset values
`define IPC_RST_SLOTS       32'h0000_0000
`define IPC_RST_PRIO        3'h0
`define IPC_RST_SUB         2'h0

`endif

/* verilog/ipc_slot_decode.v */
// one byte-wide priority slot: field split and enable decode
`timescale 1ns/10ps
`include "ipc_defines.vh"

module ipc_slot_decode
(
	// stored slot byte
	input  wire [7:0] slot_i,
	// decoded fields
	output wire [2:0] prio_o,
	output wire [1:0] sub_o,
	output wire       enable_o
);

	assign prio_o   = slot_i[`IPC_PRIO_MSB:`IPC_PRIO_LSB];
	assign sub_o    = slot_i[`IPC_SUB_MSB:`IPC_SUB_LSB];
	assign enable_o = (prio_o != `IPC_RST_PRIO);

endmodule

/* verilog/ipc_apb_decode.v */
// apb address decode for the priority block
`timescale 1ns/10ps
`include "ipc_defines.vh"

module ipc_apb_decode
(
	// bus address
	input  wire [11:0] paddr_i,
	// selects
	output wire        hit_slots_o,
	output wire        hit_status_o,
	output wire        hit_any_o
);

	assign hit_slots_o  = (paddr_i == `IPC_OFF_SLOTS);
	assign hit_status_o = (paddr_i == `IPC_OFF_STATUS);
	assign hit_any_o    = hit_slots_o | hit_status_o;

endmodule

/* verilog/ipc_top.v */
// interrupt priority slot register with apb access
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "ipc_defines.vh"

module ipc_top
#(
	// slot presence per instance, bit n keeps slot n
	parameter [3:0] SLOT_PRESENT = 4'hf
)
(
	// clock and reset
	input  wire        mclk_i,
	input  wire        reset_i,
	// apb slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [11:0] paddr_i,
	input  wire [31:0] pwdata_i,
	input  wire [3:0]  pstrb_i,
	output reg  [31:0] prdata_o,
	output reg         pready_o,
	output reg         pslverr_o,
	// decoded slot fields to the arbiter
	output reg  [11:0] slot_priority_o,
	output reg  [7:0]  slot_subpriority_o,
	output reg  [3:0]  slot_enable_o
);

	////////////////////////////////////////////////////////////////
	reg  [31:0] interrupt_priority_slots;
	wire        hit_slots;
	wire        hit_status;
	wire        hit_any;
	wire [11:0] prio_w;
	wire [7:0]  sub_w;
	wire [3:0]  en_w;
	wire        access;
	wire        wr_commit;
	reg  [31:0] next_rdata;

	ipc_apb_decode u_dec
	(
		.paddr_i      (paddr_i),
		.hit_slots_o  (hit_slots),
		.hit_status_o (hit_status),
		.hit_any_o    (hit_any)
	);

	// taken in the first access cycle, answered one cycle later (one wait state)
	assign access = psel_i & penable_i & ~pready_o;
	// writes commit only at the edge where the master sees pready high
	assign wr_commit = psel_i & penable_i & pready_o & pwrite_i;

	////////////////////////////////////////////////////////////////
	// slot storage: only the low five bits of a present slot hold state
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : gen_slot
			always @(posedge mclk_i or posedge reset_i)
			begin
				if (reset_i)
					interrupt_priority_slots[g*8 +: 8] <= 8'h00;
				else if (wr_commit & hit_slots & pstrb_i[g] & SLOT_PRESENT[g])
					interrupt_priority_slots[g*8 +: 8] <=
						pwdata_i[g*8 +: 8] & `IPC_SLOT_MASK;
			end

			ipc_slot_decode u_slot
			(
				.slot_i   (interrupt_priority_slots[g*8 +: 8]),
				.prio_o   (prio_w[g*3 +: 3]),
				.sub_o    (sub_w[g*2 +: 2]),
				.enable_o (en_w[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// read mux; status word shows which slots are live
	always @*
	begin
		next_rdata = 32'h0000_0000;
		if (hit_slots)
			next_rdata = interrupt_priority_slots;
		else if (hit_status)
			next_rdata = {28'h0000000, en_w};
	end

	always @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			prdata_o  <= 32'h0000_0000;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end
		else
		begin
			pready_o  <= access;
			pslverr_o <= access & ~hit_any;
			if (access & ~pwrite_i)
				prdata_o <= next_rdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// registered outputs; a disabled slot reaches the arbiter with enable low, but its subpriority bits still pass through unmasked
	always @(posedge mclk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			slot_priority_o    <= 12'h000;
			slot_subpriority_o <= 8'h00;
			slot_enable_o      <= 4'h0;
		end
		else
		begin
			slot_priority_o    <= prio_w;
			slot_subpriority_o <= sub_w;
			slot_enable_o      <= en_w;
		end
	end

endmodule

/* tb/ipc_top_asserts.sv */
// checker for the priority slot register
`timescale 1ns/10ps
module ipc_top_asserts #(parameter [3:0] SLOT_PRESENT=4'hf)
(
	input wire mclk_i,reset_i,pwrite_i,pready_o,
	input wire [11:0] paddr_i,slot_priority_o,
	input wire [31:0] pwdata_i,prdata_o,
	input wire [3:0] pstrb_i,slot_enable_o,
	input wire [7:0] slot_subpriority_o
);
default clocking @(posedge mclk_i); endclocking
default disable iff (reset_i);
wire rd=pready_o&&!pwrite_i&&paddr_i==0;
wire wr=pready_o&&pwrite_i&&paddr_i==0;
wire [11:0] p=slot_priority_o;
wire [7:0] s=slot_subpriority_o;
top_slot_a: assert property(rd|->prdata_o[28:24]=={p[11:9],s[7:6]}) else $error("s3");
next_slot_a: assert property(rd|->prdata_o[20:16]=={p[8:6],s[5:4]}) else $error("s2");
low_slots_a: assert property(rd|->{prdata_o[12:8],prdata_o[4:0]}=={p[5:3],s[3:2],p[2:0],s[1:0]})
	else $error("s10");
zero_bits_a: assert property(rd|->!(prdata_o&32'he0e0e0e0)) else $error("top");
prio_val_a: assert property(wr&&pstrb_i[0]|->##2 p[2:0]==$past(pwdata_i[4:2],2)) else $error("p");
sub_val_a: assert property(wr&&pstrb_i[1]|->##2 s[3:2]==$past(pwdata_i[9:8],2)) else $error("s");
src_off_a: assert property(slot_enable_o=={|p[11:9],|p[8:6],|p[5:3],|p[2:0]}) else $error("en");
absent_a: assert property(!(slot_enable_o&~SLOT_PRESENT)) else $error("abs");
cover property(wr);
cover property(pready_o&&paddr_i!=0);
cover property(slot_enable_o==4'he);
endmodule
bind ipc_top ipc_top_asserts #(.SLOT_PRESENT(SLOT_PRESENT)) u_chk(.*);

/* tb/interrupt_priority_control_test.sv */
// bench for the priority slot register
`timescale 1ns/10ps
`define CK(a,b) begin comparisons++; if((a)!==(b)) begin err_count++; \
	$display("CHECK FAILED %0t %h %h",$time,a,b); end end
module interrupt_priority_control_test;
logic mclk_i=0,reset_i=1,psel_i=0,penable_i=0,pwrite_i=0,pready_o,pslverr_o,e;
logic [11:0] paddr_i=0,slot_priority_o;
logic [31:0] pwdata_i=0,prdata_o,r;
logic [3:0] pstrb_i=0,slot_enable_o;
logic [7:0] slot_subpriority_o;
int err_count,comparisons,cyc;
ipc_top u_dut(.*);
initial forever #4 mclk_i=~mclk_i;
task summarize;
	$display("errors %0d of %0d",err_count,comparisons);
	if(err_count==0&&comparisons>0)
		$display("All tests passed");
	else
		$display("Some tests failed");
	$finish;
endtask
always @(posedge mclk_i)
	if(++cyc==500)
	begin
		err_count++;
		summarize;
	end
// request held until pready is seen at an edge
task apb(input w,input [11:0] a,input [31:0] d,input [3:0] b);
	psel_i<=1; pwrite_i<=w; paddr_i<=a; pwdata_i<=d; pstrb_i<=b;
	@(posedge mclk_i) penable_i<=1;
	@(negedge mclk_i);
	while(pready_o!==1) @(negedge mclk_i);
	r=prdata_o; e=pslverr_o;
	@(posedge mclk_i);
	psel_i<=0; penable_i<=0;
	@(posedge mclk_i);
endtask
task t_idle;
	apb(0,0,0,0);
	`CK(r,0)
	apb(0,12'h008,0,0);
	`CK({e,r},33'h100000000)
endtask
// top bits set on purpose, they must be dropped
task t_mixed;
	apb(1,0,32'heafdc608,4'hf);
	apb(0,0,0,0);
	`CK(r,32'h0a1d0608)
	`CK(slot_priority_o,12'h5ca)
	`CK(slot_subpriority_o,8'h98)
	apb(1,0,32'hffffff03,4'h1);
	apb(0,0,0,0);
	`CK(r,32'h0a1d0603)
	`CK(slot_enable_o,4'he)
endtask
initial
begin
	repeat(3) @(posedge mclk_i);
	reset_i<=0;
	t_idle;
	t_mixed;
	summarize;
end
endmodule
